/* File: design/cmpx_consts.svh */
// constants for the compressed instruction expander
// assumes includers pull it in by bare name
`ifndef CMPX_CONSTS_SVH
`define CMPX_CONSTS_SVH
// compression control codes
`define CMPX_COMPR_NORMAL 2'h0
`define CMPX_COMPR_SECOND 2'h1
`define CMPX_COMPR_PAIR 2'h2
// register file codes of an operand
`define CMPX_FILE_ARF 2'h0
`define CMPX_FILE_GRF 2'h1
`define CMPX_FILE_MRF 2'h2
`define CMPX_FILE_IMM 2'h3
// execution width codes (log2 of channel count)
`define CMPX_WIDTH_16 3'h4
`define CMPX_WIDTH_32 3'h5
// data type codes
`define CMPX_TYPE_UD 3'h0
`define CMPX_TYPE_D 3'h1
`define CMPX_TYPE_UW 3'h2
`define CMPX_TYPE_W 3'h3
`define CMPX_TYPE_F 3'h7
// stride codes and misc field values
`define CMPX_HS_ZERO 2'h0
`define CMPX_HS_ONE 2'h1
`define CMPX_VS_ZERO 4'h0
`define CMPX_THREAD_SWITCH 2'h2
`define CMPX_MRF_STRIDE4_BIT 7
`define CMPX_MRF_STEP4 8'h04
`define CMPX_MRF_STEP1 8'h01
// mask and flag half selection towards the decoder
`define CMPX_MASK_LOW8 2'h0
`define CMPX_MASK_UPPER8 2'h1
`define CMPX_MASK_FULL16 2'h2
// register byte offsets and reset values
`define CMPX_OFS_CTRL 4'h0
`define CMPX_OFS_STATUS 4'h4
`define CMPX_OFS_COUNT 4'h8
`define CMPX_CTRL_RESET 1'h0
`define CMPX_COUNT_RESET 16'h0000
`endif

/* File: design/cmpx_pkg.sv */
// types of the compressed instruction expander
// assumes the decoder uses the same instruction layout
package cmpx_pkg;
  // one operand of an instruction word
  typedef struct packed {
    logic [1:0] file;
    logic indirect;
    logic [7:0] register_number;
    logic [4:0] subreg;
    logic [1:0] horizontal_stride;
    logic [3:0] vertical_stride;
    logic [2:0] dtype;
    logic [3:0] addr_subreg;
  } cmpx_opnd_t;
  // the fields that expansion touches, the rest carried opaque
  typedef struct packed {
    logic [1:0] compr;
    logic [2:0] width;
    logic brkpt;
    logic [1:0] thread;
    logic flag_cond;
    cmpx_opnd_t dst;
    cmpx_opnd_t src0;
    cmpx_opnd_t src1;
    logic [31:0] opaque;
  } cmpx_insn_t;
  // issue sequencer states, one-hot
  typedef enum logic [3:0] {
    CMPX_IDLE = 4'h1,
    CMPX_PASS = 4'h2,
    CMPX_FIRST = 4'h4,
    CMPX_SECOND = 4'h8
  } cmpx_state_t;
endpackage

/* File: design/cmpx_expander.sv */
// compressed instruction expander: splits a compressed pair into two
// half width instructions and issues them to the decoder in order
// assumes fetch and decoder sit on sys_clk with valid/ready handshakes
//
// What this block does
// - a word with the pair compression code is expanded into two
// - pair code and direct message destination bit 7 set mean stride four
// - first copy: normal code, half width, everything else kept but stride four bit 7
// - stride four: first copy clears destination register bit 7
// - second copy: second half code and half width
// - second copy always has its breakpoint cleared
// - width below 32: second copy uses upper eight mask and flag bits
// - width 32: both copies use all sixteen mask and flag bits
// - direct vector source in second copy gets register number bit 0 set, except the packed-word case below
// - explicit accumulator source becomes the high accumulator
// - indirect vector source in second copy sets address value bit 1
// - implicit accumulator source in second copy is the high one
// - scalar or immediate sources pass unchanged into the second copy
// - width 16, dword dest and word source, stride one: subreg msb set
// - direct general file destination gets register number bit 0 set
// - explicit accumulator destination becomes the high accumulator
// - message file destination under plain pair is incremented by one
// - stride four: clear destination bit 7 then add four
// - indirect destination in second copy sets address value bit 1
// - implicit accumulator destination in second copy is the high one
// - thread control copied to both; switch forces switch on both
`timescale 1ns/1ns
`include "cmpx_consts.svh"
module cmpx_expander (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // ahb-lite register slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // instruction words from fetch
  input wire logic in_valid,
  input wire cmpx_pkg::cmpx_insn_t in_insn,
  output logic in_ready,
  // instructions to the decoder
  output logic out_valid,
  output cmpx_pkg::cmpx_insn_t out_insn,
  input wire logic out_ready,
  output logic [1:0] out_mask_mode,
  output logic out_acc_high,
  output logic out_dst_addr_bit1,
  output logic out_src0_addr_bit1,
  output logic out_src1_addr_bit1,
  output logic out_force_switch
);
  import cmpx_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    cmpx_state_t st;
    cmpx_insn_t orig;
    logic in_ready;
    logic out_valid;
    cmpx_insn_t out_insn;
    logic [1:0] mask_mode;
    logic acc_high;
    logic dst_b1;
    logic src0_b1;
    logic src1_b1;
    logic force_sw;
    logic hold;
    logic [15:0] pairs;
    logic [15:0] passes;
    logic wr_pend;
    logic [3:0] wr_ofs;
    logic [31:0] rdata;
    logic readyout;
  } cmpx_regs_t;

  cmpx_regs_t s;
  cmpx_regs_t next_s;

  // ****************************************
  // helpers
  // ****************************************
  // scalar region or immediate: never shifted for the second copy
  function automatic logic is_scalar(input cmpx_opnd_t o);
    return (o.file == `CMPX_FILE_IMM) ||
      (o.horizontal_stride == `CMPX_HS_ZERO && o.vertical_stride == `CMPX_VS_ZERO);
  endfunction

  function automatic logic is_word(input logic [2:0] t);
    return (t == `CMPX_TYPE_UW) || (t == `CMPX_TYPE_W);
  endfunction

  function automatic logic is_dword(input logic [2:0] t);
    return (t == `CMPX_TYPE_UD) || (t == `CMPX_TYPE_D) ||
      (t == `CMPX_TYPE_F);
  endfunction

  // pair code with a direct message destination whose bit 7 is set
  function automatic logic is_stride4(input cmpx_insn_t i);
    return (i.compr == `CMPX_COMPR_PAIR) &&
      (i.dst.file == `CMPX_FILE_MRF) && !i.dst.indirect &&
      i.dst.register_number[`CMPX_MRF_STRIDE4_BIT];
  endfunction

  // indirect vector operand: decoder ors bit 1 into the address value
  function automatic logic ind_b1(input cmpx_opnd_t o);
    return o.indirect && !is_scalar(o);
  endfunction

  function automatic cmpx_insn_t make_first(input cmpx_insn_t i);
    cmpx_insn_t r;
    r = i;
    r.compr = `CMPX_COMPR_NORMAL;
    r.width = i.width - 3'h1;
    if (is_stride4(i)) begin
      r.dst.register_number[`CMPX_MRF_STRIDE4_BIT] = 1'b0;
    end
    return r;
  endfunction

  // source of the second copy; the packed-word case moves half a register
  function automatic cmpx_opnd_t src_second(input cmpx_opnd_t o,
                                            input logic half_move);
    cmpx_opnd_t r;
    r = o;
    if (!is_scalar(o) && !o.indirect) begin
      if (half_move && is_word(o.dtype) && o.horizontal_stride == `CMPX_HS_ONE) begin
        r.subreg[4] = 1'b1;
      end else begin
        r.register_number[0] = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic cmpx_opnd_t dst_second(input cmpx_opnd_t o,
                                            input logic c4);
    cmpx_opnd_t r;
    r = o;
    if (!o.indirect) begin
      if (o.file == `CMPX_FILE_MRF) begin
        if (c4) begin
          r.register_number = {1'b0, o.register_number[6:0]} + `CMPX_MRF_STEP4;
        end else begin
          r.register_number = o.register_number + `CMPX_MRF_STEP1;
        end
      end else begin
        r.register_number[0] = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic cmpx_insn_t make_second(input cmpx_insn_t i);
    cmpx_insn_t r;
    logic half_move;
    half_move = (i.width == `CMPX_WIDTH_16) && is_dword(i.dst.dtype) &&
      (i.dst.horizontal_stride == `CMPX_HS_ONE);
    r = i;
    r.compr = `CMPX_COMPR_SECOND;
    r.width = i.width - 3'h1;
    r.brkpt = 1'b0;
    r.src0 = src_second(i.src0, half_move);
    r.src1 = src_second(i.src1, half_move);
    r.dst = dst_second(i.dst, is_stride4(i));
    return r;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  logic acc_in;
  logic acc_out;
  logic bus_take;
  logic [31:0] rd_val;

  always_comb begin
    acc_in = s.in_ready && in_valid;
    acc_out = s.out_valid && out_ready;
    bus_take = hsel && hready && htrans[1];
    next_s = s;
    // issue sequencer
    case (s.st)
      CMPX_IDLE: begin
        if (acc_in) begin
          next_s.out_valid = 1'b1;
          next_s.orig = in_insn;
          next_s.force_sw = (in_insn.thread == `CMPX_THREAD_SWITCH);
          next_s.dst_b1 = 1'b0;
          next_s.src0_b1 = 1'b0;
          next_s.src1_b1 = 1'b0;
          if (in_insn.compr == `CMPX_COMPR_PAIR) begin
            next_s.st = CMPX_FIRST;
            next_s.out_insn = make_first(in_insn);
            next_s.acc_high = 1'b0;
            next_s.mask_mode = (in_insn.width == `CMPX_WIDTH_32) ?
              `CMPX_MASK_FULL16 : `CMPX_MASK_LOW8;
            next_s.pairs = s.pairs + 16'h0001;
          end else begin
            // a software second half word keeps its own meaning
            next_s.st = CMPX_PASS;
            next_s.out_insn = in_insn;
            next_s.acc_high = (in_insn.compr == `CMPX_COMPR_SECOND);
            next_s.mask_mode = (in_insn.compr == `CMPX_COMPR_SECOND) ?
              `CMPX_MASK_UPPER8 : `CMPX_MASK_LOW8;
            next_s.passes = s.passes + 16'h0001;
          end
        end
      end
      CMPX_FIRST: begin
        if (acc_out) begin
          next_s.st = CMPX_SECOND;
          next_s.out_insn = make_second(s.orig);
          next_s.acc_high = 1'b1;
          next_s.mask_mode = (s.orig.width == `CMPX_WIDTH_32) ?
            `CMPX_MASK_FULL16 : `CMPX_MASK_UPPER8;
          next_s.dst_b1 = s.orig.dst.indirect;
          next_s.src0_b1 = ind_b1(s.orig.src0);
          next_s.src1_b1 = ind_b1(s.orig.src1);
        end
      end
      CMPX_PASS, CMPX_SECOND: begin
        if (acc_out) begin
          next_s.st = CMPX_IDLE;
          next_s.out_valid = 1'b0;
        end
      end
      default: begin
        next_s.st = CMPX_IDLE;
        next_s.out_valid = 1'b0;
      end
    endcase
    // hold lands first so intake closes on the very edge it is written
    if (s.wr_pend && s.wr_ofs == `CMPX_OFS_CTRL) begin
      next_s.hold = hwdata[0];
    end
    // intake only reopens once the second copy has gone; costs a bubble
    next_s.in_ready = (next_s.st == CMPX_IDLE) && !next_s.hold;
    // register read value for the address phase; unmapped reads zero
    rd_val = 32'h00000000;
    case (haddr[3:0])
      `CMPX_OFS_CTRL: rd_val = {31'h00000000, s.hold};
      `CMPX_OFS_STATUS: rd_val = {26'h0000000, s.st, s.in_ready,
                                  s.out_valid};
      `CMPX_OFS_COUNT: rd_val = {s.passes, s.pairs};
      default: rd_val = 32'h00000000;
    endcase
    if (haddr[31:4] != 28'h0000000) begin
      rd_val = 32'h00000000;
    end
    // ahb-lite slave: zero wait states, always okay
    next_s.readyout = 1'b1;
    next_s.wr_pend = bus_take && hwrite && (haddr[31:4] == 28'h0000000);
    next_s.wr_ofs = haddr[3:0];
    if (bus_take && !hwrite) begin
      next_s.rdata = rd_val;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.st <= CMPX_IDLE;
      s.hold <= `CMPX_CTRL_RESET;
      s.pairs <= `CMPX_COUNT_RESET;
      s.passes <= `CMPX_COUNT_RESET;
      s.readyout <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flip-flops, except hresp tied to zero
  assign hreadyout = s.readyout;
  assign hrdata = s.rdata;
  assign hresp = 1'b0;
  assign in_ready = s.in_ready;
  assign out_valid = s.out_valid;
  assign out_insn = s.out_insn;
  assign out_mask_mode = s.mask_mode;
  assign out_acc_high = s.acc_high;
  assign out_dst_addr_bit1 = s.dst_b1;
  assign out_src0_addr_bit1 = s.src0_b1;
  assign out_src1_addr_bit1 = s.src1_b1;
  assign out_force_switch = s.force_sw;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  logic take_pair;
  logic in_sec;
  assign take_pair = acc_in && in_insn.compr == `CMPX_COMPR_PAIR;
  assign in_sec = s.st == CMPX_SECOND;

  expand_first_a: assert property (take_pair |=>
    s.out_valid && s.out_insn.compr == `CMPX_COMPR_NORMAL &&
    s.out_insn.width == $past(in_insn.width) - 3'h1)
    else $error("pair not issued as first half");
  first_clear7_a: assert property (
    take_pair && is_stride4(in_insn) |=> !s.out_insn.dst.register_number[7])
    else $error("stride four first copy kept bit 7");
  second_code_a: assert property (
    s.st == CMPX_FIRST && out_ready |=>
    in_sec && s.out_insn.compr == `CMPX_COMPR_SECOND)
    else $error("second copy code wrong");
  second_brk_a: assert property (in_sec |-> !s.out_insn.brkpt)
    else $error("second copy breakpoint set");
  upper_mask_a: assert property (
    in_sec && s.orig.width != `CMPX_WIDTH_32 |->
    s.mask_mode == `CMPX_MASK_UPPER8)
    else $error("second copy not on upper mask");
  full_mask_a: assert property (
    s.out_valid && s.st != CMPX_PASS && s.orig.width == `CMPX_WIDTH_32
    |-> s.mask_mode == `CMPX_MASK_FULL16)
    else $error("width 32 not on full mask");
  acc_high_a: assert property (in_sec |-> s.acc_high)
    else $error("second copy not on high accumulator");
  grf_dst_a: assert property (
    in_sec && s.orig.dst.file == `CMPX_FILE_GRF && !s.orig.dst.indirect
    |-> s.out_insn.dst.register_number == (s.orig.dst.register_number | 8'h01))
    else $error("general destination not advanced");
  mrf_step_a: assert property (
    in_sec && s.orig.dst.file == `CMPX_FILE_MRF && !s.orig.dst.indirect &&
    !s.orig.dst.register_number[7] |->
    s.out_insn.dst.register_number == s.orig.dst.register_number + 8'h01)
    else $error("message destination not incremented");
  stride4_a: assert property (in_sec && is_stride4(s.orig) |->
    s.out_insn.dst.register_number == {1'b0, s.orig.dst.register_number[6:0]} + 8'h04)
    else $error("stride four destination wrong");
  intake_stall_a: assert property (
    s.st == CMPX_FIRST |-> !s.in_ready ##1 !s.in_ready)
    else $error("intake open between halves");
  thread_keep_a: assert property (in_sec |->
    s.out_insn.thread == s.orig.thread)
    else $error("thread control changed");
  // operand steps of the second copy, and what the first copy keeps
  src_move_a: assert property (
    in_sec && !s.orig.src0.indirect && !is_scalar(s.orig.src0) &&
    is_dword(s.orig.src0.dtype) |->
    s.out_insn.src0.register_number == (s.orig.src0.register_number | 8'h01))
    else $error("second copy source not advanced");
  src_ind_a: assert property (
    in_sec && s.orig.src0.indirect && !is_scalar(s.orig.src0) |->
    s.src0_b1 && s.out_insn.src0 == s.orig.src0)
    else $error("indirect source not stepped");
  scalar_keep_a: assert property (
    in_sec && is_scalar(s.orig.src0) |->
    s.out_insn.src0 == s.orig.src0 && !s.src0_b1)
    else $error("scalar source changed");
  half_move_a: assert property (
    in_sec && s.orig.width == `CMPX_WIDTH_16 &&
    is_dword(s.orig.dst.dtype) && s.orig.dst.horizontal_stride == `CMPX_HS_ONE &&
    !s.orig.src0.indirect && !is_scalar(s.orig.src0) &&
    is_word(s.orig.src0.dtype) && s.orig.src0.horizontal_stride == `CMPX_HS_ONE |->
    s.out_insn.src0.subreg[4] &&
    s.out_insn.src0.register_number == s.orig.src0.register_number)
    else $error("packed word source not moved by half");
  dst_ind_a: assert property (
    in_sec && s.orig.dst.indirect |->
    s.dst_b1 && s.out_insn.dst == s.orig.dst)
    else $error("indirect destination not stepped");
  first_keep_a: assert property (
    s.st == CMPX_FIRST |-> s.out_insn.src0 == s.orig.src0 &&
    s.out_insn.src1 == s.orig.src1 && s.out_insn.opaque == s.orig.opaque &&
    s.out_insn.brkpt == s.orig.brkpt)
    else $error("first copy altered a kept field");

  pair_c: cover property (take_pair ##[1:8] in_sec && out_ready);
  stride4_c: cover property (take_pair && is_stride4(in_insn));
  wide_c: cover property (take_pair && in_insn.width == `CMPX_WIDTH_32);
  pass_c: cover property (s.st == CMPX_PASS && out_ready);
  hold_c: cover property (s.hold && in_valid && s.st == CMPX_IDLE);
endmodule

/* File: tb/cmpx_dec_model.sv */
// decoder model at the far side of the expander: takes issued words
// assumes the bench reads the captured queue and sets the pace
`timescale 1ns/1ns
module cmpx_dec_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // pace: high makes the decoder stall three cycles in four
  input wire logic slow,
  // issued words and their side bits
  input wire logic out_valid,
  input wire cmpx_pkg::cmpx_insn_t out_insn,
  input wire logic [1:0] out_mask_mode,
  input wire logic out_acc_high,
  input wire logic out_dst_addr_bit1,
  input wire logic out_src0_addr_bit1,
  input wire logic out_src1_addr_bit1,
  input wire logic out_force_switch,
  output logic out_ready
);
  import cmpx_pkg::*;
  localparam int EW = $bits(cmpx_insn_t) + 7;
  logic [EW-1:0] got[$];
  logic [1:0] pace;
  // capture in arrival order; the bench judges the order
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pace <= 2'h0;
      out_ready <= 1'b0;
    end else begin
      if (out_valid && out_ready) begin
        got.push_back({out_insn, out_mask_mode, out_acc_high,
          out_dst_addr_bit1, out_src0_addr_bit1, out_src1_addr_bit1,
          out_force_switch});
      end
      pace <= pace + 2'h1;
      out_ready <= slow ? (pace == 2'h3) : 1'b1;
    end
  end
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the compressed instruction expander
// assumes the package, design and decoder model are compiled first
`timescale 1ns/1ns
`include "cmpx_consts.svh"
`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("wrong value at %0t: %h, expected %h", $time, g, e); \
  end \
end
module tb_top;
  import cmpx_pkg::*;
  localparam int EW = $bits(cmpx_insn_t) + 7;
  logic sys_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans, out_mask_mode;
  logic [2:0] hsize;
  logic in_valid, in_ready, out_valid, out_ready, slow;
  logic acc_h, dst_b1, s0_b1, s1_b1, fsw;
  cmpx_insn_t in_insn, out_insn, base, w;
  logic [EW-1:0] expq[$];
  logic [EW-1:0] gv, ev;
  int n_mismatch, checks_done, cyc, npair, npass;

  assign hready = hreadyout;
  always #25 sys_clk = ~sys_clk;

  cmpx_expander i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .in_valid(in_valid),
    .in_insn(in_insn), .in_ready(in_ready), .out_valid(out_valid),
    .out_insn(out_insn), .out_ready(out_ready),
    .out_mask_mode(out_mask_mode), .out_acc_high(acc_h),
    .out_dst_addr_bit1(dst_b1), .out_src0_addr_bit1(s0_b1),
    .out_src1_addr_bit1(s1_b1), .out_force_switch(fsw));
  cmpx_dec_model i_dec (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow),
    .out_valid(out_valid), .out_insn(out_insn),
    .out_mask_mode(out_mask_mode), .out_acc_high(acc_h),
    .out_dst_addr_bit1(dst_b1), .out_src0_addr_bit1(s0_b1),
    .out_src1_addr_bit1(s1_b1), .out_force_switch(fsw),
    .out_ready(out_ready));

  // ****************************************************
  // expected words and bus tasks
  // ****************************************************
  // second copy of one source; scalar and immediate stay put
  function automatic cmpx_opnd_t src2(input cmpx_opnd_t s,
      input cmpx_insn_t x, output logic ab);
    ab = 1'b0;
    if (s.file == `CMPX_FILE_IMM) return s;
    if (s.horizontal_stride == `CMPX_HS_ZERO && s.vertical_stride == `CMPX_VS_ZERO) return s;
    if (s.indirect) ab = 1'b1;
    else if (x.width == `CMPX_WIDTH_16 && x.dst.horizontal_stride == `CMPX_HS_ONE &&
        x.dst.dtype inside {`CMPX_TYPE_UD, `CMPX_TYPE_D, `CMPX_TYPE_F} &&
        s.dtype inside {`CMPX_TYPE_UW, `CMPX_TYPE_W} &&
        s.horizontal_stride == `CMPX_HS_ONE) s.subreg[4] = 1'b1;
    else s.register_number[0] = 1'b1;
    return s;
  endfunction

  // one generated copy with its side bits, as the decoder sees it
  function automatic logic [EW-1:0] expo(input cmpx_insn_t x,
      input logic sec);
    cmpx_insn_t o;
    logic [2:0] b;
    logic [1:0] mm;
    o = x;
    b = 3'h0;
    o.width = x.width - 3'h1;
    if (x.dst.file == `CMPX_FILE_MRF && !x.dst.indirect)
      o.dst.register_number[7] = 1'b0;
    mm = (x.width == `CMPX_WIDTH_32) ? `CMPX_MASK_FULL16 : `CMPX_MASK_LOW8;
    o.compr = `CMPX_COMPR_NORMAL;
    if (sec) begin
      o.compr = `CMPX_COMPR_SECOND;
      o.brkpt = 1'b0;
      if (x.width != `CMPX_WIDTH_32) mm = `CMPX_MASK_UPPER8;
      if (x.dst.indirect) b[2] = 1'b1;
      else if (x.dst.file != `CMPX_FILE_MRF) o.dst.register_number[0] = 1'b1;
      else if (x.dst.register_number[7]) o.dst.register_number += `CMPX_MRF_STEP4;
      else o.dst.register_number += `CMPX_MRF_STEP1;
      o.src0 = src2(x.src0, x, b[1]);
      o.src1 = src2(x.src1, x, b[0]);
    end
    return {o, mm, sec, b, x.thread == `CMPX_THREAD_SWITCH};
  endfunction

  // offer one word until taken, then queue what the decoder must get
  task put(input cmpx_insn_t wd);
    @(posedge sys_clk);
    in_valid <= 1'b1;
    in_insn <= wd;
    do @(posedge sys_clk); while (in_ready !== 1'b1);
    in_valid <= 1'b0;
    in_insn <= ~wd;
    if (wd.compr == `CMPX_COMPR_PAIR) begin
      npair++;
      expq.push_back(expo(wd, 1'b0));
      expq.push_back(expo(wd, 1'b1));
    end else begin
      npass++;
      expq.push_back({wd, (wd.compr == `CMPX_COMPR_SECOND) ?
        `CMPX_MASK_UPPER8 : `CMPX_MASK_LOW8,
        wd.compr == `CMPX_COMPR_SECOND, 3'h0,
        wd.thread == `CMPX_THREAD_SWITCH});
    end
  endtask

  // compare everything the decoder took, in order
  task drain;
    repeat (300) begin
      if (i_dec.got.size() == expq.size()) break;
      @(posedge sys_clk);
    end
    `CHK(i_dec.got.size(), expq.size())
    while (expq.size() > 0 && i_dec.got.size() > 0) begin
      gv = i_dec.got.pop_front();
      ev = expq.pop_front();
      `CHK(gv, ev)
    end
    expq.delete();
  endtask

  // single ahb-lite transfer; waits on hready in both phases
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
    hwdata <= ~d;
  endtask

  task rdchk(input logic [31:0] a, input logic [31:0] x);
    ahb(1'b0, a, 32'h0000_0000);
    `CHK(r, x)
    `CHK(hresp, 1'b0)
  endtask

  task final_report;
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      final_report;
    end
  end

  // ****************************************************
  // stimulus
  // ****************************************************
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata, in_valid, slow} = '0;
    hsize = 3'h2;
    in_insn = '0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rdchk(32'h0, 32'h0);
    rdchk(32'h4, 32'h6);
    rdchk(32'h8, 32'h0);
    // no nested mask pushes are issued, so codes never mix
    base = '0;
    base.compr = `CMPX_COMPR_PAIR;
    base.width = `CMPX_WIDTH_16;
    base.brkpt = 1'b1;
    base.flag_cond = 1'b1;
    base.opaque = 32'hA5C3_0F96;
    base.dst = {`CMPX_FILE_GRF, 1'b0, 8'h04, 5'h00, `CMPX_HS_ONE, 4'h0,
      `CMPX_TYPE_F, 4'h0};
    base.src0 = {`CMPX_FILE_GRF, 1'b0, 8'h02, 5'h00, `CMPX_HS_ONE, 4'h8,
      `CMPX_TYPE_F, 4'h2};
    base.src1 = {`CMPX_FILE_GRF, 1'b0, 8'h06, 5'h08, `CMPX_HS_ONE, 4'h8,
      `CMPX_TYPE_F, 4'h0};
    put(base);
    w = base;
    w.width = `CMPX_WIDTH_32;
    w.thread = `CMPX_THREAD_SWITCH;
    put(w);
    w = base;
    w.dst.file = `CMPX_FILE_MRF;
    w.dst.register_number = 8'h03;
    put(w);
    w.dst.register_number = 8'h85;
    put(w);
    w = base;
    w.dst.file = `CMPX_FILE_ARF;
    w.src0.file = `CMPX_FILE_ARF;
    w.dst.register_number = 8'h00;
    w.src0.register_number = 8'h00;
    put(w);
    w = base;
    w.src0.horizontal_stride = `CMPX_HS_ZERO;
    w.src0.vertical_stride = `CMPX_VS_ZERO;
    w.src0.indirect = 1'b1;
    w.src1.file = `CMPX_FILE_IMM;
    put(w);
    w = base;
    w.src0.indirect = 1'b1;
    w.dst.indirect = 1'b1;
    put(w);
    w = base;
    w.dst.dtype = `CMPX_TYPE_UD;
    w.src0.dtype = `CMPX_TYPE_UW;
    w.src1.dtype = `CMPX_TYPE_D;
    put(w);
    w.dst.dtype = `CMPX_TYPE_F;
    w.src0.dtype = `CMPX_TYPE_W;
    put(w);
    w = base;
    w.compr = `CMPX_COMPR_SECOND;
    put(w);
    w.compr = `CMPX_COMPR_NORMAL;
    w.width = 3'h3;
    put(w);
    drain();
    // slow decoder: second copy must still follow the first
    slow <= 1'b1;
    put(base);
    w = base;
    w.width = `CMPX_WIDTH_32;
    put(w);
    drain();
    slow <= 1'b0;
    // intake hold: nothing may be taken until it is lifted
    ahb(1'b1, 32'h0, 32'h0000_0001);
    rdchk(32'h0, 32'h1);
    fork
      put(base);
      begin
        repeat (5) @(posedge sys_clk);
        `CHK(i_dec.got.size(), 0)
        `CHK(in_ready, 1'b0)
        ahb(1'b1, 32'h0, 32'h0000_0000);
      end
    join
    drain();
    ahb(1'b1, 32'hC, 32'hFFFF_FFFF);
    rdchk(32'hC, 32'h0);
    rdchk(32'h10, 32'h0);
    rdchk(32'h8, {npass[15:0], npair[15:0]});
    final_report;
  end
endmodule
